//--- inc/metering_pkg.sv
// constants and carriers for the metering channel datapath
package metering_pkg;
  localparam int unsigned NCH = 7;
  localparam int unsigned NCUR = 4;
  localparam int unsigned SW = 24;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned SAMPLE_NS = 125000;
  localparam int unsigned SAMPLE_CYC = SAMPLE_NS / CLK_NS;
  localparam int unsigned MOD_DIV = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned HPF_SHIFT = 10;
  localparam int unsigned FRAC = 23;
  localparam int unsigned READY_BIT = 17;
  localparam int unsigned INTEGRATOR_ENABLE_BIT = 0;
  localparam logic [23:0] FULL_POS = 24'h5a7540;
  localparam logic [23:0] FULL_NEG = 24'ha58ac0;
  localparam logic [23:0] CODE_MAX = 24'h7fffff;
  localparam logic [23:0] CODE_MIN = 24'h800000;
  localparam logic [23:0] HPF_RST = 24'h000000;
  localparam logic [23:0] COEFF_RST = 24'h000000;
  localparam logic [23:0] GAIN_RST = 24'h000000;
  localparam logic [7:0] A_GAIN0 = 8'h00;
  localparam logic [7:0] A_HIGHPASS_DISABLE = 8'h10;
  localparam logic [7:0] A_COEFF = 8'h14;
  localparam logic [7:0] A_CONFIG = 8'h18;
  localparam logic [7:0] A_FIRST_STATUS_REGISTER = 8'h1c;
  localparam logic [7:0] A_FIRST_INTERRUPT_MASK = 8'h20;
  localparam logic [7:0] A_SMP0 = 8'h24;
  typedef struct packed {
    logic [NCH-1:0][SW-1:0] ch;
  } frame_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_s;
endpackage : metering_pkg

//--- verilog/metering_channel_datapath.sv
// sample fifo and the current/voltage channel datapath with its registers
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sample_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sample_fifo

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - all channels share one 24-bit code scale
// - converter codes stay within signed 24-bit range
// - current converters give 24-bit samples at 8 kSPS
// - voltage converters give same samples, chain without gain or integrator
// - current gain is one plus setting over 2^23
// - scaled current feeds everything downstream
// - gain reads as zero-topped 28-bit sign extension
// - highpass runs only while disable register is zero
// - disable register reads with eight zero top bits
// - waveform samples captured after highpass each sample
// - ready flag bit 17 set on fresh samples
// - sample registers read sign-extended from bit 23
// - integrator per current path, off at reset
// - integrator falls 20 dB/decade, about -90 degrees
// - coefficient ignored while integrator off
// - coefficient reads as zero-topped 28-bit extension
// - mask bit 17 routes ready flag to interrupt
// - modulator tick is clock divided by sixteen
module metering_channel_datapath
  import metering_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic adc_valid,
  output logic adc_ready,
  input wire frame_s adc_frame,
  output logic mod_tick,
  input wire reg_req_s reg_req,
  output logic [31:0] reg_rdata,
  output logic irq_n
);
  logic [23:0] gain_q [NCUR];
  logic [23:0] highpass_disable_q;
  logic [23:0] coeff_q;
  logic integrator_enable_q;
  logic ready_q;
  logic mask_q;
  logic [3:0] mod_cnt_q;
  logic [11:0] smp_cnt_q;
  logic tick;
  logic f_valid;
  logic pop;
  frame_s f_data;
  logic v1_q, v2_q, v3_q;
  logic [23:0] gain_s [NCUR];
  logic [27:0] coeff_s;
  logic integrator_enable_s;
  logic hpf_en_s;
  logic signed [23:0] s0_q [NCH];
  logic signed [23:0] s1_q [NCH];
  logic signed [23:0] s2_q [NCH];
  logic signed [23:0] smp_q [NCH];

  function automatic logic signed [23:0] sat24(input logic signed [63:0] v);
    if (v > $signed(64'(signed'(CODE_MAX)))) begin
      return CODE_MAX;
    end else if (v < $signed(64'(signed'(CODE_MIN)))) begin
      return CODE_MIN;
    end
    return v[23:0];
  endfunction : sat24

  function automatic logic [31:0] sext28(input logic [23:0] v);
    return {4'h0, {4{v[23]}}, v};
  endfunction : sext28

  //////////////////////////////////////////////////////////////////////////////
  // timing: modulator tick and sample strobe both come from core_clk
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mod_cnt_q <= '0;
      mod_tick <= 1'b0;
    end else begin
      mod_cnt_q <= mod_cnt_q + 1'b1;
      mod_tick <= (mod_cnt_q == 4'(MOD_DIV - 1));
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      smp_cnt_q <= '0;
    end else if (tick) begin
      smp_cnt_q <= '0;
    end else begin
      smp_cnt_q <= smp_cnt_q + 1'b1;
    end
  end
  assign tick = (smp_cnt_q == 12'(SAMPLE_CYC - 1));

  //////////////////////////////////////////////////////////////////////////////
  // converter frames queue here; a late consumer lets the queue fill
  sample_fifo #(.WIDTH($bits(frame_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(adc_valid),
    .in_ready(adc_ready),
    .in_data(adc_frame),
    .out_valid(f_valid),
    .out_ready(tick),
    .out_data(f_data)
  );
  assign pop = tick && f_valid;

  //////////////////////////////////////////////////////////////////////////////
  // settings are frozen per sample so a write never splits one in flight
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      v1_q <= 1'b0;
      v2_q <= 1'b0;
      v3_q <= 1'b0;
      integrator_enable_s <= 1'b0;
      hpf_en_s <= 1'b1;
      coeff_s <= '0;
    end else begin
      v1_q <= pop;
      v2_q <= v1_q;
      v3_q <= v2_q;
      if (pop) begin
        integrator_enable_s <= integrator_enable_q;
        hpf_en_s <= (highpass_disable_q == HPF_RST);
        coeff_s <= 28'(sext28(coeff_q));
      end
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic signed [31:0] acc_q;
    logic signed [31:0] dc_q;
    logic signed [49:0] prod;
    logic signed [31:0] acc_d;
    logic signed [59:0] leak;
    logic signed [31:0] diff;
    logic cur;
    assign cur = (i < NCUR);
    if (i < NCUR) begin : g_gain
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          gain_s[i] <= GAIN_RST;
        end else if (pop) begin
          gain_s[i] <= gain_q[i];
        end
      end
      assign prod = s0_q[i] * $signed({2'b01, 23'h0} + 25'(signed'(gain_s[i])));
    end else begin : g_nogain
      assign prod = s0_q[i] * $signed({2'b01, 23'h0});
    end
    assign leak = acc_q * $signed(coeff_s);
    assign acc_d = acc_q + 32'(s1_q[i]) + 32'(leak >>> FRAC);
    assign diff = 32'(s2_q[i]) - dc_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        s0_q[i] <= '0;
        s1_q[i] <= '0;
        s2_q[i] <= '0;
        smp_q[i] <= '0;
        acc_q <= '0;
        dc_q <= '0;
      end else begin
        if (pop) begin
          s0_q[i] <= f_data.ch[i];
        end
        if (v1_q) begin
          s1_q[i] <= sat24(64'(prod >>> FRAC));
        end
        if (v2_q) begin
          // leaky accumulator: -20 dB/dec and near -90 deg in band
          if (cur && integrator_enable_s) begin
            acc_q <= acc_d;
            s2_q[i] <= sat24(64'(acc_d));
          end else begin
            acc_q <= '0;
            s2_q[i] <= s1_q[i];
          end
        end
        if (v3_q) begin
          if (hpf_en_s) begin
            dc_q <= dc_q + (diff >>> HPF_SHIFT);
            smp_q[i] <= sat24(64'(diff));
          end else begin
            smp_q[i] <= s2_q[i];
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register port
  for (genvar g = 0; g < NCUR; g++) begin : g_gainreg
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        gain_q[g] <= GAIN_RST;
      end else if (reg_req.wr && reg_req.addr == A_GAIN0 + 8'(4 * g)) begin
        gain_q[g] <= reg_req.wdata[23:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      highpass_disable_q <= HPF_RST;
      coeff_q <= COEFF_RST;
      integrator_enable_q <= 1'b0;
      mask_q <= 1'b0;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        A_HIGHPASS_DISABLE: highpass_disable_q <= reg_req.wdata[23:0];
        A_COEFF: coeff_q <= reg_req.wdata[23:0];
        A_CONFIG: integrator_enable_q <= reg_req.wdata[INTEGRATOR_ENABLE_BIT];
        A_FIRST_INTERRUPT_MASK: mask_q <= reg_req.wdata[READY_BIT];
        default: ;
      endcase
    end
  end

  // a fresh capture beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_q <= 1'b0;
    end else if (v3_q) begin
      ready_q <= 1'b1;
    end else if (reg_req.wr && reg_req.addr == A_FIRST_STATUS_REGISTER && reg_req.wdata[READY_BIT]) begin
      ready_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(ready_q && mask_q);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_req.rd) begin
      reg_rdata <= '0;
      if (reg_req.addr < A_HIGHPASS_DISABLE && reg_req.addr[1:0] == 2'b00) begin
        reg_rdata <= sext28(gain_q[reg_req.addr[3:2]]);
      end
      if (reg_req.addr >= A_SMP0 && reg_req.addr < A_SMP0 + 8'(4 * NCH)
          && reg_req.addr[1:0] == 2'b00) begin
        reg_rdata <= 32'(smp_q[3'((reg_req.addr - A_SMP0) >> 2)]);
      end
      unique case (reg_req.addr)
        A_HIGHPASS_DISABLE: reg_rdata <= {8'h00, highpass_disable_q};
        A_COEFF: reg_rdata <= sext28(coeff_q);
        A_CONFIG: reg_rdata <= 32'(integrator_enable_q) << INTEGRATOR_ENABLE_BIT;
        A_FIRST_STATUS_REGISTER: reg_rdata <= 32'(ready_q) << READY_BIT;
        A_FIRST_INTERRUPT_MASK: reg_rdata <= 32'(mask_q) << READY_BIT;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_pipe;
    v1_q ##1 v2_q ##1 v3_q;
  endsequence

  chk_pipe_capture: assert property (pop |-> ##1 s_pipe)
    else $error("sample did not reach capture in three cycles");
  chk_ready_set: assert property (v3_q |=> ready_q)
    else $error("ready flag not set after capture");
  chk_irq_gate: assert property ($rose(ready_q) && mask_q |=> !irq_n)
    else $error("masked-in ready flag did not raise interrupt");
  chk_tick_space: assert property (tick |=> (!tick)[*8])
    else $error("sample strobes too close");
  chk_gain_unity: assert property (v1_q && gain_s[0] == '0 |=> s1_q[0] == $past(s0_q[0]))
    else $error("zero gain changed the sample");
  chk_integ_off: assert property (v2_q && !integrator_enable_s |=> s2_q[0] == $past(s1_q[0]))
    else $error("disabled integrator altered the sample");
  chk_hpf_bypass: assert property (v3_q && !hpf_en_s |=> smp_q[0] == $past(s2_q[0]))
    else $error("highpass not bypassed");
  chk_highpass_disable_pad: assert property (reg_req.rd && reg_req.addr == A_HIGHPASS_DISABLE
                                   |=> reg_rdata[31:24] == 8'h00)
    else $error("disable register top byte not zero");
  chk_mod_tick: assert property (mod_tick |=> (!mod_tick)[*8])
    else $error("modulator tick spacing wrong");
endmodule : metering_channel_datapath

`default_nettype wire

//--- sim/host_model.sv
// register host model driving the strobed register port
`timescale 1ns/10ps
`default_nettype none
module host_model
  import metering_pkg::*;
(
  input wire logic core_clk,
  output var reg_req_s reg_req,
  input wire logic [31:0] reg_rdata
);
  initial reg_req = '0;
  // a released port shows inverted address and data, never the last values
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'hffffffff};
    #1;
    d = reg_rdata;
  endtask : read_reg
endmodule : host_model
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the metering channel datapath
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import metering_pkg::*;
;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic adc_valid = 1'b0;
  logic adc_ready, mod_tick, irq_n;
  frame_s adc_frame = '0;
  reg_req_s reg_req;
  logic [31:0] reg_rdata, rd;
  int failures = 0;
  int num_checks = 0;
  logic [23:0] g_tab [4] = '{24'h400000, 24'hc00000, 24'h000000, 24'h800000};
  localparam logic [31:0] DI_COEFF = 32'h0fff8000;

  always #25 core_clk = ~core_clk;

  metering_channel_datapath u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_frame(adc_frame),
    .mod_tick(mod_tick), .reg_req(reg_req), .reg_rdata(reg_rdata), .irq_n(irq_n));
  host_model u_host (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] scaled(logic [23:0] x, logic [23:0] g);
    logic signed [49:0] p;
    p = ($signed(x) * ($signed(g) + 50'sh800000)) >>> 23;
    if (p > 50'sh7fffff) p = 50'sh7fffff;
    else if (p < -50'sh800000) p = -50'sh800000;
    return {{8{p[23]}}, p[23:0]};
  endfunction : scaled

  // one integrator step: running sum less a leak set by the loaded coefficient
  function automatic int integ(int acc, int x);
    return acc + x + int'((longint'(acc) * longint'($signed(DI_COEFF[27:0]))) >>> 23);
  endfunction : integ

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic give_up(input string name);
    chk(name, 32'h1, 32'h0);
    print_verdict();
  endtask : give_up

  // frame is held until the fifo takes it
  task automatic push(input frame_s f);
    int n;
    @(posedge core_clk);
    adc_valid <= 1'b1;
    adc_frame <= f;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (adc_ready !== 1'b1 && n < 6000);
    if (adc_ready !== 1'b1) give_up("push timeout");
    @(posedge core_clk);
    adc_valid <= 1'b0;
  endtask : push

  task automatic wait_ready();
    int n;
    for (n = 0; n < 2000; n++) begin
      u_host.read_reg(A_FIRST_STATUS_REGISTER, rd);
      if (rd[READY_BIT] === 1'b1) return;
    end
    give_up("ready timeout");
  endtask : wait_ready

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    frame_s f;
    logic [23:0] g;
    int i, k;
    int s;
    int acc_m [4] = '{default: 0};
    int dc_m [NCH] = '{default: 0};
    void'($urandom(32'h9ae8f30e));
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    // 0x00..0x3c mapped, 0x40 unmapped: all read zero after reset
    for (i = 0; i < 17; i++) begin
      u_host.read_reg(8'(4 * i), rd);
      chk("reset value", 32'h0, rd);
    end
    k = 0;
    repeat (160) begin
      @(posedge core_clk);
      #1;
      k += int'(mod_tick);
    end
    chk("tick count", 32'd10, 32'(k));
    for (i = 0; i < 4; i++) begin
      g = 24'($urandom);
      u_host.write_reg(8'(4 * i), {8'($urandom), g});
      u_host.read_reg(8'(4 * i), rd);
      chk("gain read", {4'h0, {4{g[23]}}, g}, rd);
    end
    g = 24'($urandom) | 24'h000001;
    u_host.write_reg(A_HIGHPASS_DISABLE, {8'($urandom), g});
    u_host.read_reg(A_HIGHPASS_DISABLE, rd);
    chk("highpass disable read", {8'h00, g}, rd);
    u_host.write_reg(A_COEFF, 32'h0fff8000);
    u_host.read_reg(A_COEFF, rd);
    chk("coefficient read", 32'h0fff8000, rd);
    u_host.write_reg(8'h40, 32'hffffffff);
    u_host.read_reg(8'h40, rd);
    chk("unmapped read", 32'h0, rd);
    u_host.write_reg(A_FIRST_INTERRUPT_MASK, 32'h00020000);
    // bypassed highpass, integrator off with a live coefficient
    for (k = 0; k < 6; k++) begin
      g = (k < 4) ? g_tab[k] : (k == 4) ? 24'h7fffff : 24'h400000;
      for (i = 0; i < 4; i++) u_host.write_reg(8'(4 * i), {8'h00, g});
      for (i = 0; i < NCH; i++) begin
        f.ch[i] = (k == 4) ? CODE_MAX : (k == 5) ? CODE_MIN : 24'($urandom) & 24'hfffffe;
      end
      push(f);
      wait_ready();
      chk("irq asserted", 32'h0, {31'h0, irq_n});
      for (i = 0; i < NCH; i++) begin
        u_host.read_reg(8'(A_SMP0 + 4 * i), rd);
        chk("sample", (i < NCUR) ? scaled(f.ch[i], g) : {{8{f.ch[i][23]}}, f.ch[i]}, rd);
      end
      u_host.write_reg(A_FIRST_STATUS_REGISTER, 32'h00020000);
      u_host.read_reg(A_FIRST_STATUS_REGISTER, rd);
      chk("ready cleared", 32'h0, rd & 32'h00020000);
      chk("irq released", 32'h1, {31'h0, irq_n});
    end
    // unity gain, integrator and highpass both live; small codes keep clear of saturation
    for (i = 0; i < 4; i++) u_host.write_reg(8'(4 * i), 32'h00000000);
    u_host.write_reg(A_HIGHPASS_DISABLE, 32'h00000000);
    u_host.write_reg(A_CONFIG, 32'h00000001);
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < NCH; i++) begin
        g = 24'($urandom);
        f.ch[i] = {{4{g[19]}}, g[19:0]};
      end
      push(f);
      wait_ready();
      for (i = 0; i < NCH; i++) begin
        s = int'($signed(f.ch[i]));
        if (i < NCUR) begin
          acc_m[i] = integ(acc_m[i], s);
          s = acc_m[i];
        end
        s = s - dc_m[i];
        dc_m[i] += s >>> HPF_SHIFT;
        u_host.read_reg(8'(A_SMP0 + 4 * i), rd);
        chk("filtered sample", 32'(s), rd);
      end
      u_host.write_reg(A_FIRST_STATUS_REGISTER, 32'h00020000);
    end
    // fill the fifo until it refuses, then hold the frame until a pop frees room
    @(posedge core_clk);
    adc_valid <= 1'b1;
    i = 0;
    for (k = 0; k < 40; k++) begin
      @(negedge core_clk);
      if (!adc_ready) break;
      i++;
      @(posedge core_clk);
    end
    chk("fifo depth", FIFO_DEPTH, 32'(i));
    for (k = 0; k < 3000 && !adc_ready; k++) @(negedge core_clk);
    chk("fifo room after pop", 32'h1, {31'h0, adc_ready});
    @(posedge core_clk);
    adc_valid <= 1'b0;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
